// ### hw/kscw_wake.sv
// keyboard scan code wake detector with its registers and event gate
`timescale 1ns/1ps
module kscw_wake
  import kscw_pkg::*;
(
  // clock and standby reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // power state
  input wire logic main_power_on_in,
  input wire logic ext_slow_clock_in,
  // keyboard lines
  input wire logic kbd_clk_in,
  input wire logic kbd_data_in,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  // wake status and enable
  input wire logic wake_status_clear_in,
  input wire logic wake_enable_key_in,
  input wire logic global_wake_enable_in,
  input wire logic other_wake_pending_in,
  output logic wake_status_out,
  output logic power_event_out
);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  logic [DATA_W-1:0] scan_code_reg;
  kscw_cfg_t cfg_reg;
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic ext_prev_reg;
  logic kclk_prev_reg;
  logic [HI_W-1:0] hi_cnt_reg;
  logic [HI_W-1:0] hi_cnt_next;
  kscw_state_t state_reg;
  kscw_state_t state_next;
  logic [BIT_CNT_W-1:0] bit_cnt_reg;
  logic [BIT_CNT_W-1:0] bit_cnt_next;
  logic [DATA_W-1:0] shift_reg;
  logic [DATA_W-1:0] shift_next;
  logic start_ok_reg;
  logic start_ok_next;
  logic match_reg;
  logic match_next;
  logic status_reg;
  logic status_next;
  logic pme_reg;
  logic [DATA_W-1:0] rdata_next;

  // register decode
  wire sel_code = (reg_addr_in == OFS_WAKE_SCAN_CODE);
  wire sel_cfg = (reg_addr_in == OFS_SLOW_CLOCK_CONFIG);
  wire wr_code = reg_wr_in & sel_code;
  wire wr_cfg = reg_wr_in & sel_cfg;
  wire [DATA_W-1:0] cfg_word = {{(DATA_W - 2){1'b0}}, cfg_reg};
  assign rdata_next = !reg_rd_in ? READ_ZERO :
                      sel_code ? scan_code_reg :
                      sel_cfg ? cfg_word : READ_ZERO;

  // power state comes from another domain; resets low, so standby first
  wire main_on_s;
  kscw_sync #(.WIDTH(1)) u_pwr_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .en_in(1'b1),
    .async_in(main_power_on_in),
    .sync_out(main_on_s)
  );

  // slow clock source; internal divider only lives on main power
  wire key_off = cfg_reg.key_off;
  wire use_ext = cfg_reg.ext_present | ~main_on_s;
  wire div_run = main_on_s & ~use_ext & ~key_off;
  wire int_tick = div_run & (div_reg == DIV_LAST);
  assign div_next = (!div_run || int_tick) ? '0 : div_reg + 9'h001;

  wire ext_s;
  kscw_sync #(.WIDTH(1)) u_ext_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .en_in(1'b1),
    .async_in(ext_slow_clock_in),
    .sync_out(ext_s)
  );
  wire ext_rise = ext_s & ~ext_prev_reg;
  // gating the enable stands in for stopping the slow clock
  wire slow_tick = ~key_off & (use_ext ? ext_rise : int_tick);

  // keyboard lines sampled on slow ticks only
  wire [1:0] kbd_s;
  kscw_sync #(.WIDTH(2)) u_kbd_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .en_in(slow_tick),
    .async_in({kbd_clk_in, kbd_data_in}),
    .sync_out(kbd_s)
  );
  wire kclk_s = kbd_s[1];
  wire kdat_s = kbd_s[0];
  wire kclk_fall = slow_tick & kclk_prev_reg & ~kclk_s;

  // high-time measure; low resets it
  assign hi_cnt_next = !slow_tick ? hi_cnt_reg :
                       !kclk_s ? '0 : sat_inc(hi_cnt_reg);
  wire idle_seen = (hi_cnt_reg >= IDLE_TICKS_C);
  wire too_long = (hi_cnt_reg > ABORT_TICKS_C);

  wire at_data = (bit_cnt_reg < EDGE_DATA_LAST);
  wire at_parity = (bit_cnt_reg == EDGE_PARITY - 4'h1);
  wire at_stop = (bit_cnt_reg == EDGE_STOP - 4'h1);
  wire [DATA_W-1:0] shifted = {kdat_s, shift_reg[DATA_W-1:1]};
  wire frame_good = (shift_reg == scan_code_reg)
                    & odd_ones(shift_reg, kdat_s) & start_ok_reg;
  wire hit = (state_reg == ST_RECV) & kclk_fall & at_stop
             & match_reg & kdat_s;

  // frame sequencer
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    start_ok_next = start_ok_reg;
    match_next = match_reg;
    if (key_off) begin
      state_next = ST_HUNT;
      bit_cnt_next = '0;
      match_next = 1'b0;
    end else begin
      case (state_reg)
        ST_HUNT: begin
          if (slow_tick && idle_seen) begin
            state_next = ST_READY;
          end
        end
        ST_READY: begin
          if (kclk_fall) begin
            state_next = ST_RECV;
            bit_cnt_next = EDGE_START;
            start_ok_next = ~kdat_s;
            match_next = 1'b0;
          end
        end
        ST_RECV: begin
          if (slow_tick && too_long) begin
            state_next = ST_HUNT;
            bit_cnt_next = '0;
            match_next = 1'b0;
          end else if (kclk_fall) begin
            bit_cnt_next = bit_cnt_reg + 4'h1;
            if (at_data) begin
              shift_next = shifted;
            end
            if (at_parity) begin
              match_next = frame_good;
            end
            if (at_stop) begin
              state_next = ST_HUNT;
              bit_cnt_next = '0;
            end
          end
        end
        default: begin
          state_next = ST_HUNT;
          bit_cnt_next = '0;
        end
      endcase
    end
  end

  // sticky status; a set in the clear cycle wins
  assign status_next = hit | (status_reg & ~wake_status_clear_in);
  wire pme_next = global_wake_enable_in
                  & ((status_reg & wake_enable_key_in)
                     | other_wake_pending_in);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scan_code_reg <= SCAN_CODE_RST;
      cfg_reg <= CFG_RST;
      reg_rdata_out <= READ_ZERO;
    end else begin
      if (wr_code) begin
        scan_code_reg <= reg_wdata_in;
      end
      if (wr_cfg) begin
        cfg_reg.ext_present <= reg_wdata_in[CFG_EXT_PRESENT_BIT];
        cfg_reg.key_off <= reg_wdata_in[CFG_KEY_OFF_BIT];
      end
      reg_rdata_out <= rdata_next;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_reg <= '0;
      ext_prev_reg <= 1'b0;
      kclk_prev_reg <= 1'b0;
      hi_cnt_reg <= '0;
    end else begin
      div_reg <= div_next;
      ext_prev_reg <= ext_s;
      if (slow_tick) begin
        kclk_prev_reg <= kclk_s;
      end
      hi_cnt_reg <= hi_cnt_next;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_HUNT;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      start_ok_reg <= 1'b0;
      match_reg <= 1'b0;
      status_reg <= 1'b0;
      pme_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      start_ok_reg <= start_ok_next;
      match_reg <= match_next;
      status_reg <= status_next;
      pme_reg <= pme_next;
    end
  end

  assign wake_status_out = status_reg;
  assign power_event_out = pme_reg;

  // checks
  a_code_write_lands: assert property (
    wr_code |=> scan_code_reg == $past(reg_wdata_in))
    else $error("scan code write not stored");

  a_status_sticky: assert property (
    status_reg && !wake_status_clear_in |=> status_reg)
    else $error("wake status dropped without clear");

  a_status_cause: assert property (
    $rose(status_reg) |-> $past(match_reg && kdat_s && kclk_fall))
    else $error("wake status set without matching frame");

  a_match_parity: assert property (
    $rose(match_reg) |-> $past(odd_ones(shift_reg, kdat_s) && start_ok_reg))
    else $error("match accepted with bad parity or start");

  a_start_after_idle: assert property (
    state_reg == ST_READY |-> hi_cnt_reg >= IDLE_TICKS_C)
    else $error("frame armed without idle interval");

  a_eleven_edges: assert property (
    state_reg == ST_RECV |-> bit_cnt_reg < EDGE_STOP)
    else $error("frame ran past eleven edges");

  a_abort_long_high: assert property (
    state_reg == ST_RECV && slow_tick && too_long && !key_off
    |=> state_reg == ST_HUNT && bit_cnt_reg == 4'h0)
    else $error("long clock high did not abort frame");

  a_off_no_tick: assert property (
    key_off |-> !slow_tick)
    else $error("matcher ticking while switched off");

  a_off_hunt: assert property (
    key_off ##1 key_off |-> state_reg == ST_HUNT)
    else $error("frame state kept while switched off");

  a_standby_ext_only: assert property (
    !main_on_s |-> !int_tick)
    else $error("internal slow clock used on standby");

  a_event_gate: assert property (
    ##1 power_event_out == $past(global_wake_enable_in
      && ((status_reg && wake_enable_key_in) || other_wake_pending_in)))
    else $error("power event gating wrong");

  a_frame_start: assert property (
    state_reg == ST_READY && kclk_fall
    |=> state_reg == ST_RECV && bit_cnt_reg == EDGE_START)
    else $error("frame did not start at first fall");

  a_start_bit: assert property (
    state_reg == ST_READY && kclk_fall |=> start_ok_reg == !$past(kdat_s))
    else $error("start bit not recorded");

  a_match_fresh: assert property (
    state_reg == ST_READY && kclk_fall |=> !match_reg)
    else $error("match left over from earlier frame");

  a_data_shift: assert property (
    state_reg == ST_RECV && kclk_fall && !too_long
    && bit_cnt_reg < EDGE_DATA_LAST
    |=> shift_reg[DATA_W-1] == $past(kdat_s))
    else $error("data bit not shifted in");

  a_parity_kept_out: assert property (
    state_reg == ST_RECV && kclk_fall && at_parity |=> $stable(shift_reg))
    else $error("parity bit shifted into data");

  a_stop_to_hunt: assert property (
    state_reg == ST_RECV && kclk_fall && at_stop
    |=> state_reg == ST_HUNT && bit_cnt_reg == '0)
    else $error("frame not closed at eleventh edge");

  a_high_count_reset: assert property (
    slow_tick && !kclk_s |=> hi_cnt_reg == '0)
    else $error("clock high time not restarted by low");

  a_read_code: assert property (
    reg_rd_in && sel_code |=> reg_rdata_out == $past(scan_code_reg))
    else $error("scan code read returned wrong data");

  a_read_idle: assert property (
    !reg_rd_in |=> reg_rdata_out == READ_ZERO)
    else $error("read data not idle without a read");

  a_cfg_write: assert property (
    wr_cfg
    |=> cfg_reg.ext_present == $past(reg_wdata_in[CFG_EXT_PRESENT_BIT])
    && cfg_reg.key_off == $past(reg_wdata_in[CFG_KEY_OFF_BIT]))
    else $error("slow clock config write not stored");

  a_status_clear: assert property (
    wake_status_clear_in && !hit |=> !status_reg)
    else $error("wake status survived its clear");

endmodule : kscw_wake

// ### hw/kscw_pkg.sv
// constants, types and helpers shared by the scan code wake block
package kscw_pkg;

  // register offsets and widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_WAKE_SCAN_CODE = 8'h5f;
  localparam logic [ADDR_W-1:0] OFS_SLOW_CLOCK_CONFIG = 8'hf0;

  // field positions
  localparam int unsigned CFG_EXT_PRESENT_BIT = 0;
  localparam int unsigned CFG_KEY_OFF_BIT = 1;
  localparam int unsigned WAKE_KEY_BIT = 5;

  // reset values
  localparam logic [DATA_W-1:0] SCAN_CODE_RST = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  // frame layout, counted in falling keyboard clock edges
  localparam int unsigned BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] EDGE_START = 4'h1;
  localparam logic [BIT_CNT_W-1:0] EDGE_DATA_LAST = 4'h9;
  localparam logic [BIT_CNT_W-1:0] EDGE_PARITY = 4'ha;
  localparam logic [BIT_CNT_W-1:0] EDGE_STOP = 4'hb;

  // timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SLOW_HZ = 32_768;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned IDLE_MIN_US = 115;
  localparam int unsigned IDLE_MAX_US = 145;
  localparam int unsigned INT_DIV = CLK_HZ / SLOW_HZ;
  localparam int unsigned IDLE_TICKS =
    (IDLE_MIN_US * SLOW_HZ + US_PER_S - 1) / US_PER_S;
  localparam int unsigned ABORT_TICKS = (IDLE_MAX_US * SLOW_HZ) / US_PER_S;
  localparam int unsigned DIV_W = 9;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INT_DIV - 1);
  localparam int unsigned HI_W = 3;
  localparam logic [HI_W-1:0] HI_SAT = 3'h7;
  localparam logic [HI_W-1:0] IDLE_TICKS_C = HI_W'(IDLE_TICKS);
  localparam logic [HI_W-1:0] ABORT_TICKS_C = HI_W'(ABORT_TICKS);

  // frame states, gray along hunt -> ready -> receive
  typedef enum logic [1:0] {
    ST_HUNT = 2'b00,
    ST_READY = 2'b01,
    ST_RECV = 2'b11
  } kscw_state_t;

  // slow clock configuration fields
  typedef struct packed {
    logic key_off;
    logic ext_present;
  } kscw_cfg_t;

  localparam kscw_cfg_t CFG_RST = '{key_off: 1'b0, ext_present: 1'b0};

  // odd parity over data and parity bit
  function automatic logic odd_ones(input logic [DATA_W-1:0] d,
                                    input logic p);
    odd_ones = ^{d, p};
  endfunction : odd_ones

  // saturating increment for the high-time counter
  function automatic logic [HI_W-1:0] sat_inc(input logic [HI_W-1:0] v);
    sat_inc = (v == HI_SAT) ? HI_SAT : v + 3'h1;
  endfunction : sat_inc

endpackage : kscw_pkg

// ### hw/kscw_sync.sv
// two-stage synchroniser with sample enable
`timescale 1ns/1ps
module kscw_sync #(
  parameter int unsigned WIDTH = 2
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // sampling
  input wire logic en_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  // first stage feeds only the second
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1_reg <= '0;
      sync_out <= '0;
    end else if (en_in) begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end

endmodule : kscw_sync

// ### tb/kscw_kbd_model.sv
// keyboard model driving the serial clock and data lines
`timescale 1ns/1ps
module kscw_kbd_model (
  // clock
  input wire logic clk_in,
  // keyboard lines, open drain with pull-ups, so idle is high
  output logic kbd_clk_out,
  output logic kbd_data_out
);
  initial begin
    kbd_clk_out = 1'b1;
    kbd_data_out = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask : hold

  // t is the slow tick in clk cycles; clock stays high long after bit stall
  task automatic send_frame(input logic [7:0] d, input logic par_bad,
      input logic stop_b, input int t, input int stall);
    logic [10:0] bits;
    bits = {stop_b, ~^d ^ par_bad, d, 1'b0};
    hold(8 * t);
    for (int i = 0; i < 11; i++) begin
      kbd_data_out <= bits[i];
      hold(t);
      kbd_clk_out <= 1'b0;
      hold(2 * t);
      kbd_clk_out <= 1'b1;
      // data released to the pull-up between bits
      kbd_data_out <= 1'b1;
      hold(i == stall ? 8 * t : t);
    end
    hold(4 * t);
  endtask : send_frame
endmodule : kscw_kbd_model

// ### tb/tb_keyboard_scan_code_wake.sv
// self-checking bench for the scan code wake block
`timescale 1ns/1ps
module tb_keyboard_scan_code_wake;
  import kscw_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic main_power_on_in = 1'b1;
  logic ext_slow_clock_in = 1'b0;
  logic ext_run = 1'b1;
  logic [1:0] div = 2'h0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic clr_in = 1'b0;
  logic en_in = 1'b0;
  logic glob_in = 1'b0;
  logic other_in = 1'b0;
  logic wake_status_out;
  logic power_event_out;
  logic kbd_clk;
  logic kbd_data;
  int err_count = 0;
  int comparisons = 0;
  localparam logic [7:0] CODE = 8'h1d;

  initial forever #50 clk_in = ~clk_in;
  // external slow clock, period 8 clk cycles to keep frames short
  always @(posedge clk_in) begin
    div <= div + 2'h1;
    if (ext_run && div == 2'h3) ext_slow_clock_in <= ~ext_slow_clock_in;
  end

  kscw_wake i_kscw_wake (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .main_power_on_in(main_power_on_in),
    .ext_slow_clock_in(ext_slow_clock_in), .kbd_clk_in(kbd_clk),
    .kbd_data_in(kbd_data), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .wake_status_clear_in(clr_in), .wake_enable_key_in(en_in),
    .global_wake_enable_in(glob_in), .other_wake_pending_in(other_in),
    .wake_status_out(wake_status_out),
    .power_event_out(power_event_out));

  kscw_kbd_model i_kscw_kbd_model (.clk_in(clk_in),
    .kbd_clk_out(kbd_clk), .kbd_data_out(kbd_data));

  task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 chk("read data", e, reg_rdata_out);
  endtask : rd

  task automatic clr();
    @(posedge clk_in);
    clr_in <= 1'b1;
    @(posedge clk_in);
    clr_in <= 1'b0;
  endtask : clr

  task automatic frame(input logic [7:0] d, input logic pb, input logic sb,
      input int t, input int stall, input logic e);
    i_kscw_kbd_model.send_frame(d, pb, sb, t, stall);
    #1 chk("wake status", {7'h0, e}, {7'h0, wake_status_out});
    clr();
  endtask : frame

  task automatic ev(input logic en, input logic g, input logic o,
      input logic e);
    @(posedge clk_in);
    en_in <= en;
    glob_in <= g;
    other_in <= o;
    repeat (2) @(posedge clk_in);
    #1 chk("power event", {7'h0, e}, {7'h0, power_event_out});
  endtask : ev

  task automatic t_regs();
    rd(OFS_WAKE_SCAN_CODE, SCAN_CODE_RST);
    rd(OFS_SLOW_CLOCK_CONFIG, 8'h00);
    wr(8'h5e, 8'hff);
    rd(8'h5e, READ_ZERO);
    wr(OFS_WAKE_SCAN_CODE, CODE);
    rd(OFS_WAKE_SCAN_CODE, CODE);
    wr(OFS_SLOW_CLOCK_CONFIG, 8'hff);
    rd(OFS_SLOW_CLOCK_CONFIG, 8'h03);
    wr(OFS_SLOW_CLOCK_CONFIG, 8'h01);
  endtask : t_regs

  task automatic t_frames();
    frame(CODE, 1'b0, 1'b1, 8, 99, 1'b1);
    frame(8'hb8, 1'b0, 1'b1, 8, 99, 1'b0);
    frame(8'h1c, 1'b0, 1'b1, 8, 99, 1'b0);
    frame(CODE, 1'b1, 1'b1, 8, 99, 1'b0);
    frame(CODE, 1'b0, 1'b0, 8, 99, 1'b0);
    frame(CODE, 1'b0, 1'b1, 8, 4, 1'b0);
    frame(CODE, 1'b0, 1'b1, 8, 99, 1'b1);
  endtask : t_frames

  task automatic t_event();
    i_kscw_kbd_model.send_frame(CODE, 1'b0, 1'b1, 8, 99);
    ev(1'b1, 1'b1, 1'b0, 1'b1);
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    ev(1'b0, 1'b1, 1'b0, 1'b0);
    ev(1'b0, 1'b1, 1'b1, 1'b1);
    chk("sticky status", 8'h01, {7'h0, wake_status_out});
    clr();
    ev(1'b1, 1'b1, 1'b0, 1'b0);
  endtask : t_event

  task automatic t_power();
    wr(OFS_SLOW_CLOCK_CONFIG, 8'h03);
    frame(CODE, 1'b0, 1'b1, 8, 99, 1'b0);
    wr(OFS_SLOW_CLOCK_CONFIG, 8'h00);
    main_power_on_in <= 1'b0;
    frame(CODE, 1'b0, 1'b1, 8, 99, 1'b1);
    ext_run <= 1'b0;
    frame(CODE, 1'b0, 1'b1, 8, 99, 1'b0);
    main_power_on_in <= 1'b1;
    // internal divider tick, so the model slows to 305 clk per tick
    frame(CODE, 1'b0, 1'b1, 305, 99, 1'b1);
  endtask : t_power

  task automatic tally_and_finish();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_frames();
    t_event();
    t_power();
    tally_and_finish();
  end

  // the whole run needs about 22000 cycles
  initial begin
    repeat (60000) @(posedge clk_in);
    err_count++;
    tally_and_finish();
  end
endmodule : tb_keyboard_scan_code_wake
